// ---- rtl/coe_clock_output_enable_sbi.sv ----
// What this block does
// - High rate pair runs only with power good, pin low, register bit, sideband enable.
// - Power good low: low rate 0-1 and selectable off; low rate 2 follows early good.
// - Power good is active high; first rise captures the address straps.
// - After first rise, power good low requests power down; high restarts clocks.
// - Two low samples on complement rising edges commit power down at complement fall; each pair but low rate 2 parks at its source's next rise.
// - Stable clocks appear less than 5 ms after power good rises.
// - Parked outputs are driven again within 300 us of power good rising.
// - Every enable or disable takes effect without shortened phases.
// - Each of seven high rate outputs has an active low enable pin.
// - Nineteen outputs plus platform time have register enable bits resetting enabled.
// - With shift/load high, each sideband clock rise shifts data in.
// - Shift/load falling edge copies the shift register to the latched enables.
// - With shift/load low, sideband clock and data are ignored.
// - Mask bit set forces that output's sideband enable true.
// - First bit shifted is platform time enable, last is high rate output zero.
// - Sideband clock is at most 25 MHz; any rate up to it is accepted.
// - Daisy chain: serial out feeds next device; controller shifts combined count.
// - Latched sideband register reads raw, without mask; mask uses same order.
`timescale 1ns/1ps

module coe_clock_output_enable_sbi
  import coe_pkg::*;
#(
  parameter int RESTART_CYC = RESTART_CYC_DEF
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire coe_wb_req_t  wb_i,
  output coe_wb_rsp_t       wb_o,
  input  wire logic         power_good_in_i,
  input  wire logic         early_25m_power_good_i,
  input  wire logic         sideband_clock_i,
  input  wire logic         sideband_data_in_i,
  input  wire logic         shift_load_n_i,
  input  wire logic         mux_select_lf_i,
  input  wire logic [6:0]   hf_enable_n_i,
  input  wire logic [3:0]   bus_address_strap_i,
  output logic              sideband_data_out_o,
  output coe_clk_out_t      clk_o
);

  coe_state_t st;
  coe_state_t next_st;

  // Raw pins gathered for the two-stage synchroniser
  logic [SY_W-1:0] pins;
  assign pins = {bus_address_strap_i, hf_enable_n_i, mux_select_lf_i, shift_load_n_i,
                 sideband_data_in_i, sideband_clock_i, early_25m_power_good_i,
                 power_good_in_i};

  // Synchronised pin levels, all read from the second stage only
  logic       pg;
  logic       epg;
  logic       sbc;
  logic       sbd;
  logic       sld;
  logic       mux_lf;
  logic [6:0] oe_n;
  assign pg     = st.s2[SY_PG];
  assign epg    = st.s2[SY_EPG];
  assign sbc    = st.s2[SY_SBC];
  assign sbd    = st.s2[SY_SBD];
  assign sld    = st.s2[SY_SLD];
  assign mux_lf = st.s2[SY_MUX];
  assign oe_n   = st.s2[SY_OE +: 7];

  // Source clock edges, decoded from the dividers one cycle ahead
  logic hf_tick;
  logic lf_tick;
  logic hf_rise;
  logic hf_fall;
  logic lf_rise;
  logic hf_nxt;
  logic lf_nxt;
  assign hf_tick = (st.hf_div == HF_HALF - 3'h1);
  assign lf_tick = (st.lf_div == LF_HALF - 3'h1);
  assign hf_rise = hf_tick & ~st.hf_src;
  assign hf_fall = hf_tick & st.hf_src; // Complement rising edge
  assign lf_rise = lf_tick & ~st.lf_src;
  assign hf_nxt  = st.hf_src ^ hf_tick;
  assign lf_nxt  = st.lf_src ^ lf_tick;

  // Power down commits at the complement falling edge after two low samples
  logic going_down;
  logic run_now;
  assign going_down = (st.pwr == PWR_RUN) & (st.pd_cnt == 2'(PD_SAMPLES)) & hf_rise;
  assign run_now    = (st.pwr == PWR_RUN) & ~going_down;

  // Sideband strobes
  logic sb_rise;
  logic sb_load;
  assign sb_rise = sbc & ~st.sbclk_d & sld;
  assign sb_load = st.sld_d & ~sld;

  // Per output: wanted enable, safe update edge and next source level
  logic [NOUT-1:0] want;
  logic [NOUT-1:0] upd;
  logic [NOUT-1:0] lvl;
  logic [NOUT-1:0] sb_en;
  assign sb_en = st.mask | st.latch;

  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      if (gi < NHF) begin : g_hf
        // High rate pair also needs its own pin low
        assign want[gi] = run_now & ~oe_n[gi] & st.oe[gi] & sb_en[gi];
        assign upd[gi]  = hf_rise;
        assign lvl[gi]  = hf_nxt;
      end else if (gi == IDX_LF2) begin : g_lf2
        // Early power good keeps this pair alive outside the run state
        assign want[gi] = run_now ? (st.oe[gi] & sb_en[gi]) : epg;
        assign upd[gi]  = lf_rise;
        assign lvl[gi]  = lf_nxt;
      end else if (gi >= IDX_SEL && gi < IDX_PFT) begin : g_sel
        // Source select is assumed static while the pair runs
        assign want[gi] = run_now & st.oe[gi] & sb_en[gi];
        assign upd[gi]  = mux_lf ? lf_rise : hf_rise;
        assign lvl[gi]  = mux_lf ? lf_nxt : hf_nxt;
      end else begin : g_lf
        assign want[gi] = run_now & st.oe[gi] & sb_en[gi];
        assign upd[gi]  = lf_rise;
        assign lvl[gi]  = lf_nxt;
      end
    end
  endgenerate

  // Byte-lane write mask over the 20 enable bits
  function automatic logic [19:0] wmask(input logic [3:0] s);
    wmask = {{4{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Bus request seen for the first time
  logic       wb_req;
  logic [19:0] wm;
  assign wb_req = wb_i.cyc & wb_i.stb & ~st.ack;
  assign wm     = wmask(wb_i.sel);

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;

    // Pin synchroniser and edge history
    next_st.s1      = pins;
    next_st.s2      = st.s1;
    next_st.sbclk_d = sbc;
    next_st.sld_d   = sld;

    // High rate source divider
    if (hf_tick) begin
      next_st.hf_div = 3'h0;
      next_st.hf_src = ~st.hf_src;
    end else begin
      next_st.hf_div = st.hf_div + 3'h1;
    end

    // Low rate source divider
    if (lf_tick) begin
      next_st.lf_div = 3'h0;
      next_st.lf_src = ~st.lf_src;
    end else begin
      next_st.lf_div = st.lf_div + 3'h1;
    end

    // Shift register: first bit in ends at the top, bit 19
    if (sb_rise) begin
      next_st.sr = {st.sr[18:0], sbd};
    end
    if (sb_load) begin
      next_st.latch = st.sr;
    end

    // Power sequencing
    case (st.pwr)
      PWR_WAIT: begin
        if (pg) begin
          next_st.strap = st.s2[SY_STRAP +: 4];
          next_st.cnt   = 21'h0;
          next_st.pwr   = PWR_START;
        end
      end
      PWR_START: begin
        // Restart delay sits well inside both power-up limits
        if (!pg) begin
          next_st.pwr = PWR_DOWN;
        end else if (st.cnt == 21'(RESTART_CYC - 1)) begin
          next_st.pwr = PWR_RUN;
        end else begin
          next_st.cnt = st.cnt + 21'h1;
        end
      end
      PWR_RUN: begin
        // Count consecutive low samples on complement rising edges
        if (going_down) begin
          next_st.pd_cnt = 2'h0;
          next_st.pwr    = PWR_DOWN;
        end else if (hf_fall && st.pd_cnt != 2'(PD_SAMPLES)) begin
          next_st.pd_cnt = pg ? 2'h0 : st.pd_cnt + 2'h1;
        end
      end
      PWR_DOWN: begin
        if (pg) begin
          next_st.cnt = 21'h0;
          next_st.pwr = PWR_START;
        end
      end
      default: begin
        next_st.pwr = PWR_WAIT;
      end
    endcase

    // Gates change only at their source's rising edge, so no phase is cut short
    next_st.gate  = (st.gate & ~upd) | (want & upd);
    next_st.out_p = lvl & next_st.gate;
    next_st.out_n = ~lvl & next_st.gate; // Disabled pairs park low/low

    // Wishbone slave: one ack per request, unmapped reads return zero
    next_st.ack  = wb_req;
    next_st.rdat = 32'h0;
    if (wb_req) begin
      if (wb_i.we) begin
        case (wb_i.adr)
          ADR_OE: begin
            next_st.oe = (st.oe & ~wm) | (wb_i.dat[19:0] & wm);
          end
          ADR_MASK: begin
            next_st.mask = (st.mask & ~wm) | (wb_i.dat[19:0] & wm);
          end
          default: begin
            next_st.rdat = 32'h0;
          end
        endcase
      end else begin
        case (wb_i.adr)
          ADR_OE: begin
            next_st.rdat = {12'h000, st.oe};
          end
          ADR_MASK: begin
            next_st.rdat = {12'h000, st.mask};
          end
          ADR_LATCH: begin
            next_st.rdat = {12'h000, st.latch};
          end
          ADR_STAT: begin
            next_st.rdat = {20'h00000, st.strap, 1'b0, st.pwr, epg, pg, st.pd_cnt};
          end
          ADR_GATE: begin
            next_st.rdat = {12'h000, st.gate};
          end
          ADR_SHIFT: begin
            next_st.rdat = {12'h000, st.sr};
          end
          default: begin
            next_st.rdat = 32'h0;
          end
        endcase
      end
    end
  end

  // State register; reset parks every pair and restores enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= '0;
      st.oe   <= OE_RST;
      st.mask <= MASK_RST;
      st.pwr  <= PWR_WAIT;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign wb_o.ack            = st.ack;
  assign wb_o.dat            = st.rdat;
  assign sideband_data_out_o = st.sr[19];
  assign clk_o.out_p         = st.out_p;
  assign clk_o.out_n         = st.out_n;

endmodule // coe_clock_output_enable_sbi

// ---- rtl/coe_pkg.sv ----
package coe_pkg;

  // Output layout: 0-6 high rate, 7-9 low rate, 10-18 selectable, 19 platform time
  localparam int NOUT    = 20;
  localparam int NHF     = 7;
  localparam int IDX_LF  = 7;
  localparam int IDX_LF2 = 9;
  localparam int IDX_SEL = 10;
  localparam int IDX_PFT = 19;

  // Register byte offsets
  localparam logic [7:0] ADR_OE    = 8'h00;
  localparam logic [7:0] ADR_MASK  = 8'h04;
  localparam logic [7:0] ADR_LATCH = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_GATE  = 8'h10;
  localparam logic [7:0] ADR_SHIFT = 8'h14;

  // Reset values
  localparam logic [19:0] OE_RST   = 20'hFFFFF;
  localparam logic [19:0] MASK_RST = 20'h00000;

  // Timing
  localparam int CLK_MHZ         = 250;
  localparam int T_STABLE_US     = 5000;
  localparam int T_DRIVE_US      = 300;
  localparam int STABLE_MAX_CYC  = T_STABLE_US * CLK_MHZ;
  localparam int DRIVE_MAX_CYC   = T_DRIVE_US * CLK_MHZ;
  localparam int RESTART_CYC_DEF = 1000;
  localparam int PD_SAMPLES      = 2;
  localparam logic [2:0] HF_HALF = 3'h2;
  localparam logic [2:0] LF_HALF = 3'h5;

  // Positions in the synchroniser vector
  localparam int SY_PG    = 0;
  localparam int SY_EPG   = 1;
  localparam int SY_SBC   = 2;
  localparam int SY_SBD   = 3;
  localparam int SY_SLD   = 4;
  localparam int SY_MUX   = 5;
  localparam int SY_OE    = 6;
  localparam int SY_STRAP = 13;
  localparam int SY_W     = 17;

  typedef enum logic [2:0] {
    PWR_WAIT,
    PWR_START,
    PWR_RUN,
    PWR_DOWN
  } coe_pwr_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } coe_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } coe_wb_rsp_t;

  typedef struct packed {
    logic [19:0] out_p;
    logic [19:0] out_n;
  } coe_clk_out_t;

  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic            sbclk_d;
    logic            sld_d;
    coe_pwr_t        pwr;
    logic [20:0]     cnt;
    logic [1:0]      pd_cnt;
    logic            hf_src;
    logic            lf_src;
    logic [2:0]      hf_div;
    logic [2:0]      lf_div;
    logic [19:0]     oe;
    logic [19:0]     mask;
    logic [19:0]     latch;
    logic [19:0]     sr;
    logic [19:0]     gate;
    logic [3:0]      strap;
    logic            ack;
    logic [31:0]     rdat;
    logic [19:0]     out_p;
    logic [19:0]     out_n;
  } coe_state_t;

endpackage

// ---- verif/coe_monitor.sv ----
`timescale 1ns/1ps
module coe_monitor
  import coe_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire coe_wb_req_t  wb_i,
  input wire coe_wb_rsp_t  wb_o,
  input wire logic         power_good_in_i,
  input wire logic         early_25m_power_good_i,
  input wire logic         shift_load_n_i,
  input wire logic [6:0]   hf_enable_n_i,
  input wire logic         sideband_data_out_o,
  input wire coe_clk_out_t clk_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Long quiet windows are chained eight-cycle holds to keep unrolling small
  sequence pg_lo8; (!power_good_in_i) [*8]; endsequence
  sequence all_lo8; (!power_good_in_i && !early_25m_power_good_i) [*8]; endsequence
  sequence pin_off8; hf_enable_n_i[0] [*8]; endsequence
  sequence req; wb_i.cyc && wb_i.stb && !wb_o.ack; endsequence

  ack_next_a: assert property (req |=> wb_o.ack) else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack) else $error("ack held too long");
  unmapped_read_a: assert property ((req ##0 (!wb_i.we && wb_i.adr == 8'h20)) |=> wb_o.dat == 32'h0)
    else $error("unmapped read not zero");
  pin_off_a: assert property (pin_off8 ##1 pin_off8 |-> !clk_o.out_p[0] && !clk_o.out_n[0])
    else $error("pin disabled output still runs");
  pd_park_a: assert property (pg_lo8 ##1 pg_lo8 ##1 pg_lo8 ##1 pg_lo8 |->
    ((clk_o.out_p | clk_o.out_n) & 20'hFFDFF) == 20'h0) else $error("outputs not parked");
  lf2_off_a: assert property (all_lo8 ##1 all_lo8 ##1 all_lo8 ##1 all_lo8 |->
    !clk_o.out_p[IDX_LF2] && !clk_o.out_n[IDX_LF2]) else $error("early pair runs unpowered");
  sb_hold_a: assert property ((!shift_load_n_i) [*8] |-> $stable(sideband_data_out_o))
    else $error("serial out moved while load low");
  pair_excl_a: assert property ((clk_o.out_p & clk_o.out_n) == 20'h0)
    else $error("true and complement both high");
  // A started high phase must run its full length, never cut by a gate change
  phase_hf_a: assert property ($rose(clk_o.out_p[0]) |=> clk_o.out_p[0])
    else $error("high rate phase cut short");
  phase_lf_a: assert property ($rose(clk_o.out_p[IDX_LF]) |=> clk_o.out_p[IDX_LF] [*4])
    else $error("low rate phase cut short");
endmodule // coe_monitor

bind coe_clock_output_enable_sbi coe_monitor MON (.clk_i, .rst_i, .wb_i, .wb_o, .power_good_in_i,
  .early_25m_power_good_i, .shift_load_n_i, .hf_enable_n_i, .sideband_data_out_o, .clk_o);

// ---- verif/coe_sb_model.sv ----
`timescale 1ns/1ps
module coe_sb_model (
  output logic sideband_clock_o,
  output logic sideband_data_o,
  output logic shift_load_n_o
);
  // Idle levels follow the pins' pull-downs; the clock stands still between frames
  initial begin
    sideband_clock_o = 1'b0;
    sideband_data_o  = 1'b0;
    shift_load_n_o   = 1'b0;
  end
  // One frame, 48 ns per bit; odd start offset keeps edges off the block clock
  task automatic send(input logic [39:0] w, input int n);
    #1.3 shift_load_n_o = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      sideband_data_o = w[i];
      #24 sideband_clock_o = 1'b1;
      #24 sideband_clock_o = 1'b0;
    end
    #24 shift_load_n_o = 1'b0;
    sideband_data_o = 1'b0;
    #48;
  endtask
  // Clock and data traffic with load parked low
  task automatic noise();
    #1.3;
    for (int i = 0; i < 4; i++) begin
      sideband_data_o = ~sideband_data_o;
      #24 sideband_clock_o = 1'b1;
      #24 sideband_clock_o = 1'b0;
    end
    sideband_data_o = 1'b0;
  endtask
endmodule // coe_sb_model

// ---- verif/test_clock_output_enable_sbi.sv ----
`timescale 1ns/1ps
module test_clock_output_enable_sbi
  import coe_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  coe_wb_req_t  wb_i  = '0;
  logic         pg    = 1'b0;
  logic         epg   = 1'b0;
  logic [6:0]   hen_n = 7'h00;
  logic         mux   = 1'b0;
  logic [3:0]   sp    = 4'h0;
  coe_wb_rsp_t  wb_o;
  coe_clk_out_t clk_o;
  logic         sck, sdi, sld, sdo;
  logic [31:0]  expq[$];
  logic [19:0]  r, m, s, d, acc;
  logic [6:0]   h;
  int           err_total, comparisons, cyc_cnt;

  always #2 clk_i = ~clk_i;

  coe_clock_output_enable_sbi #(.RESTART_CYC(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_o(wb_o), .power_good_in_i(pg), .early_25m_power_good_i(epg), .sideband_clock_i(sck),
    .sideband_data_in_i(sdi), .shift_load_n_i(sld), .mux_select_lf_i(mux), .hf_enable_n_i(hen_n),
    .bus_address_strap_i(sp), .sideband_data_out_o(sdo), .clk_o(clk_o));
  coe_sb_model SBM (.sideband_clock_o(sck), .sideband_data_o(sdi), .shift_load_n_o(sld));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Classic cycle: hold everything until ack is sampled, then idle one cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] dt);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hF, dt};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Read data checked at the ack edge against the oldest note
  always @(posedge clk_i) begin
    if (wb_o.ack === 1'b1 && wb_i.we === 1'b0) chk(wb_o.dat, expq.pop_front());
  end
  // Hang guard, far above the roughly 1100 cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    void'($urandom(53));
    // Straps and source select settle during reset, before power good rises
    sp  <= 4'($urandom);
    mux <= 1'($urandom);
    wt(12);
    rst_i <= 1'b0;
    wt(1);
    rd(ADR_OE, 32'hFFFFF);
    rd(ADR_MASK, 32'h0);
    bus(1'b1, ADR_LATCH, 32'hABCDE);
    rd(ADR_LATCH, 32'h0);
    rd(8'h20, 32'h0);
    pg <= 1'b1;
    wt(60);
    rd(ADR_STAT, {20'h0, sp, 8'h24});
    rd(ADR_GATE, 32'h0);
    r = 20'($urandom);
    h = 7'($urandom);
    hen_n <= h;
    bus(1'b1, ADR_OE, {12'h0, r});
    bus(1'b1, ADR_MASK, 32'hFFFFF);
    wt(20);
    rd(ADR_GATE, {12'h0, r & ~{13'h0, h}});
    bus(1'b1, ADR_MASK, 32'h0);
    s = 20'($urandom);
    SBM.send({20'h0, s}, 20);
    wt(8);
    rd(ADR_LATCH, {12'h0, s});
    chk({31'h0, sdo}, {31'h0, s[19]});
    m = 20'($urandom);
    bus(1'b1, ADR_MASK, {12'h0, m});
    wt(20);
    rd(ADR_GATE, {12'h0, r & ~{13'h0, h} & (m | s)});
    rd(ADR_LATCH, {12'h0, s});
    SBM.noise();
    wt(8);
    rd(ADR_SHIFT, {12'h0, s});
    d = 20'($urandom);
    SBM.send({s, d}, 40);
    wt(8);
    rd(ADR_LATCH, {12'h0, d});
    // Power down, then only the early pair may come back
    pg <= 1'b0;
    wt(40);
    chk({12'h0, clk_o.out_p | clk_o.out_n}, 32'h0);
    epg <= 1'b1;
    acc = '0;
    repeat (40) begin
      @(posedge clk_i);
      acc = acc | clk_o.out_p;
    end
    chk({12'h0, acc}, 32'h200);
    pg <= 1'b1;
    epg <= 1'b0;
    wt(60);
    rd(ADR_GATE, {12'h0, r & ~{13'h0, h} & (m | d)});
    end_of_test();
  end
endmodule // test_clock_output_enable_sbi
